// *** isc_regs.vh ***
// Register map, field positions and opcodes of the interrupt status and command block.
// Assumes a classic Wishbone slave with 32-bit data and byte addresses.
`ifndef ISC_REGS_VH
`define ISC_REGS_VH
// Offsets are register indexes; byte address = 4 * index
`define ISC_IDX_INT_LOW        8'h0e
`define ISC_IDX_INT_HIGH       8'h0f
`define ISC_IDX_CMD            8'h10
`define ISC_IDX_EVENT_MASK     8'h20
`define ISC_IDX_BYTE_COUNT     8'h21
`define ISC_IDX_COMPARE        8'h22
`define ISC_IDX_MODE_STATE     8'h23
// Low status byte fields
`define ISC_LO_DONE            7
`define ISC_LO_PAUSED          6
`define ISC_LO_OUT_OFF         5
`define ISC_LO_ERROR           0
// High status byte fields
`define ISC_HI_DEC_EOR         7
`define ISC_HI_CMP             6
`define ISC_HI_B_ONE           5
`define ISC_HI_B_EOR           4
`define ISC_HI_A_ONE           1
`define ISC_HI_A_EOR           0
// Opcodes
`define ISC_OP_NOP             16'h0000
`define ISC_OP_SEL_A           16'hc100
`define ISC_OP_SEL_B           16'hc200
`define ISC_OP_PAUSE           16'h4200
`define ISC_OP_SOFT_RESET      16'ha000
`define ISC_OP_C_BYPASS        12'h500
`define ISC_OP_COMPRESS        12'h580
`define ISC_OP_D_BYPASS        12'h600
`define ISC_OP_DECOMPRESS      12'h680
`define ISC_OP_D_OUT_OFF       12'h6c0
// Reset values
`define ISC_RST_CMD_HW         16'h0000
`define ISC_RST_STATUS         8'h00
// Software reset length
`define ISC_SOFT_RESET_CLOCKS  12
`endif

// *** isc_core.v ***
// Interrupt status flags and command decode of a compression coprocessor.
// Assumes a classic Wishbone master and datapath event pulses synchronous to clk_i.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "isc_regs.vh"

// Function
// - Writing zero clears flag, one keeps; error flag ignores the write
// - Done sets at output port completion
// - Paused sets on pause or transfer event
// - Done, paused, output-off clear on resets/compress start
// - Output-off sets after last suppressed record end
// - Error sets on unmasked error, sticky
// - Masked port flags set at transfer end
// - Decoder record end on code or error
// - Compare sets when count reaches compare
// - Second port single byte flag conditions
// - Second port record end flag conditions
// - First port single byte flag conditions
// - First port record end flag conditions
// - High byte clears on resets/compress start
// - Command zero hardware, soft reset opcode
// - First port select enables its registers
// - Second port select enables its registers
// - Compression opcodes start, pad fields
// - Decompression opcodes start, pad fields
// - Pause floats buses, sets paused
// - Soft reset clears state, twelve clocks
// - Unmasked error status raises error flag
module isc_core #(
  parameter CW = 32
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire [31:0]   adr_i,
  input  wire [31:0]   dat_i,
  output reg  [31:0]   dat_o,
  input  wire [3:0]    sel_i,
  input  wire          we_i,
  input  wire          cyc_i,
  input  wire          stb_i,
  output reg           ack_o,
  input  wire          out_port_done_i,
  input  wire          xfer_event_i,
  input  wire          suppressed_last_eor_i,
  input  wire [7:0]    error_status_i,
  input  wire [7:0]    error_mask_i,
  input  wire          decoder_record_end_i,
  input  wire          decoder_code_error_i,
  input  wire          b_byte_i,
  input  wire          b_last_i,
  input  wire          b_one_i,
  input  wire          a_byte_i,
  input  wire          a_last_i,
  input  wire          a_one_i,
  input  wire          xfer_last_word_i,
  input  wire          record_length_zero_i,
  output reg           first_port_cfg_en_o,
  output reg           second_port_cfg_en_o,
  output reg           start_pulse_o,
  output reg  [2:0]    mode_o,
  output reg  [1:0]    pad_expect_o,
  output reg  [1:0]    pad_insert_o,
  output reg           pause_o,
  output reg           bus_float_o,
  output reg           soft_reset_o,
  output reg  [7:0]    interrupt_status_low_o,
  output reg  [7:0]    interrupt_status_high_o
);

  // ****************************************
  // Mode codes
  // ****************************************
  localparam M_IDLE = 3'd0;
  localparam M_CBYP = 3'd1;
  localparam M_COMP = 3'd2;
  localparam M_DBYP = 3'd3;
  localparam M_DCMP = 3'd4;
  localparam M_DOFF = 3'd5;

  reg  [7:0]    int_low;
  reg  [7:0]    int_high;
  reg  [15:0]   command_opcode;
  reg  [3:0]    event_mask;
  reg  [CW-1:0] byte_count;
  reg  [CW-1:0] compare_count;
  reg  [2:0]    mode;
  reg  [3:0]    sr_count;
  reg  [7:0]    next_low;
  reg  [7:0]    next_high;
  reg  [7:0]    set_low;
  reg  [7:0]    set_high;
  reg  [2:0]    wr_mode;
  reg  [31:0]   rd_data;

  wire       req      = cyc_i & stb_i & ~ack_o;
  wire [7:0] idx      = adr_i[9:2];
  wire       wr       = req & we_i;
  wire       wr_low   = wr & (idx == `ISC_IDX_INT_LOW) & sel_i[0];
  wire       wr_high  = wr & (idx == `ISC_IDX_INT_HIGH) & sel_i[0];
  wire       wr_cmd   = wr & (idx == `ISC_IDX_CMD) & (&sel_i[1:0]) & ~soft_reset_o;
  wire       wr_emask = wr & (idx == `ISC_IDX_EVENT_MASK) & sel_i[0];
  wire       wr_cmp   = wr & (idx == `ISC_IDX_COMPARE);
  wire       comp_mode = (mode == M_CBYP) | (mode == M_COMP);
  wire       dbyp_mode = (mode == M_DBYP);
  wire       active   = (mode != M_IDLE);
  wire       count_reached = (byte_count >= compare_count);
  wire       pause_cmd = wr_cmd & (dat_i[15:0] == `ISC_OP_PAUSE);
  wire       a_record_end = comp_mode ? record_length_zero_i : (a_last_i & active);
  // A set mask bit holds its port flag back until the final word
  wire [3:0] mask_ok  = ~event_mask | {4{xfer_last_word_i}};
  wire       any_err  = |(error_status_i & ~error_mask_i);

  // ****************************************
  // Command decode
  // ****************************************
  always @* begin
    if (dat_i[15:4] == `ISC_OP_C_BYPASS) begin
      wr_mode = M_CBYP;
    end else if (dat_i[15:4] == `ISC_OP_COMPRESS) begin
      wr_mode = M_COMP;
    end else if (dat_i[15:4] == `ISC_OP_D_BYPASS) begin
      wr_mode = M_DBYP;
    end else if (dat_i[15:4] == `ISC_OP_DECOMPRESS) begin
      wr_mode = M_DCMP;
    end else if (dat_i[15:4] == `ISC_OP_D_OUT_OFF) begin
      wr_mode = M_DOFF;
    end else begin
      wr_mode = M_IDLE;
    end
  end

  wire start     = wr_cmd & (wr_mode != M_IDLE);
  wire comp_new  = start & ((wr_mode == M_CBYP) | (wr_mode == M_COMP));
  wire clr_all   = comp_new | soft_reset_o;

  // ****************************************
  // Status flag set terms
  // ****************************************
  always @* begin
    set_low  = 8'h00;
    set_high = 8'h00;
    if (out_port_done_i) begin
      set_low[`ISC_LO_DONE] = 1'b1;
    end
    if (pause_cmd || xfer_event_i) begin
      set_low[`ISC_LO_PAUSED] = 1'b1;
    end
    if (suppressed_last_eor_i) begin
      set_low[`ISC_LO_OUT_OFF] = 1'b1;
    end
    if (any_err) begin
      set_low[`ISC_LO_ERROR] = 1'b1;
    end
    if (decoder_record_end_i || decoder_code_error_i) begin
      set_high[`ISC_HI_DEC_EOR] = 1'b1;
    end
    // Idle mode keeps a zero compare count from flagging at once
    if (active && count_reached) begin
      set_high[`ISC_HI_CMP] = 1'b1;
    end
    if (mask_ok[3] && b_last_i && (comp_mode || dbyp_mode)) begin
      set_high[`ISC_HI_B_EOR] = 1'b1;
    end
    if (mask_ok[2] && b_last_i && b_one_i && (comp_mode || dbyp_mode)) begin
      set_high[`ISC_HI_B_ONE] = 1'b1;
    end
    if (mask_ok[1] && a_record_end) begin
      set_high[`ISC_HI_A_EOR] = 1'b1;
    end
    if (mask_ok[0] && a_record_end && a_one_i) begin
      set_high[`ISC_HI_A_ONE] = 1'b1;
    end
  end

  // ****************************************
  // Status flag next values; sets win over clears
  // ****************************************
  always @* begin
    next_low  = int_low;
    next_high = int_high;
    if (clr_all) begin
      next_low  = `ISC_RST_STATUS;
      next_high = `ISC_RST_STATUS;
    end
    if (wr_low) begin
      // Error flag is not cleared by an interrupt reset
      next_low  = next_low & {dat_i[7:1], 1'b1};
    end
    if (wr_high) begin
      next_high = next_high & dat_i[7:0];
    end
    // An event in the clearing cycle must not be lost
    next_low  = next_low | set_low;
    next_high = next_high | set_high;
    // Reserved bits always read zero
    next_low[4:1]  = 4'h0;
    next_high[3:2] = 2'b00;
  end

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    rd_data = 32'h0000_0000;
    if (idx == `ISC_IDX_INT_LOW) begin
      rd_data = {24'h00_0000, int_low};
    end else if (idx == `ISC_IDX_INT_HIGH) begin
      rd_data = {24'h00_0000, int_high};
    end else if (idx == `ISC_IDX_CMD) begin
      rd_data = {16'h0000, command_opcode};
    end else if (idx == `ISC_IDX_EVENT_MASK) begin
      rd_data = {28'h000_0000, event_mask};
    end else if (idx == `ISC_IDX_BYTE_COUNT) begin
      rd_data = byte_count;
    end else if (idx == `ISC_IDX_COMPARE) begin
      rd_data = compare_count;
    end else if (idx == `ISC_IDX_MODE_STATE) begin
      rd_data = {27'h000_0000, soft_reset_o, pause_o, mode};
    end
  end

  // ****************************************
  // Bus answer
  // ****************************************
  // Ack is registered, so every access costs two cycles
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (req && !we_i) begin
        dat_o <= rd_data;
      end else begin
        dat_o <= 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Status registers
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      int_low                 <= `ISC_RST_STATUS;
      int_high                <= `ISC_RST_STATUS;
      interrupt_status_low_o  <= `ISC_RST_STATUS;
      interrupt_status_high_o <= `ISC_RST_STATUS;
    end else begin
      int_low                 <= next_low;
      int_high                <= next_high;
      interrupt_status_low_o  <= next_low;
      interrupt_status_high_o <= next_high;
    end
  end

  // ****************************************
  // Mask, compare and byte count
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      event_mask    <= 4'h0;
      compare_count <= {CW{1'b0}};
      byte_count    <= {CW{1'b0}};
    end else if (soft_reset_o) begin
      // Writes inside the soft reset window are dropped
      event_mask    <= 4'h0;
      compare_count <= {CW{1'b0}};
      byte_count    <= {CW{1'b0}};
    end else begin
      if (wr_emask) begin
        event_mask <= dat_i[3:0];
      end
      if (wr_cmp) begin
        compare_count <= dat_i[CW-1:0];
      end
      // Count is restarted only by a compression start or a soft reset
      if (comp_new) begin
        byte_count <= {CW{1'b0}};
      end else if (b_byte_i) begin
        byte_count <= byte_count + {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // Command register and mode
  // ****************************************
  always @(posedge clk_i) begin
    if (rst_i) begin
      command_opcode       <= `ISC_RST_CMD_HW;
      mode                 <= M_IDLE;
      sr_count             <= 4'h0;
      first_port_cfg_en_o  <= 1'b0;
      second_port_cfg_en_o <= 1'b0;
      start_pulse_o        <= 1'b0;
      mode_o               <= M_IDLE;
      pad_expect_o         <= 2'b00;
      pad_insert_o         <= 2'b00;
      pause_o              <= 1'b0;
      bus_float_o          <= 1'b0;
      soft_reset_o         <= 1'b0;
    end else begin
      start_pulse_o <= start;
      if (wr_cmd) begin
        command_opcode       <= dat_i[15:0];
        first_port_cfg_en_o  <= (dat_i[15:0] == `ISC_OP_SEL_A);
        second_port_cfg_en_o <= (dat_i[15:0] == `ISC_OP_SEL_B);
        if (start) begin
          mode         <= wr_mode;
          mode_o       <= wr_mode;
          pad_expect_o <= dat_i[3:2];
          pad_insert_o <= dat_i[1:0];
          pause_o      <= 1'b0;
          bus_float_o  <= 1'b0;
        end
        if (dat_i[15:0] == `ISC_OP_PAUSE) begin
          pause_o     <= 1'b1;
          bus_float_o <= 1'b1;
        end
        if (dat_i[15:0] == `ISC_OP_SOFT_RESET) begin
          soft_reset_o <= 1'b1;
          sr_count     <= 4'd`ISC_SOFT_RESET_CLOCKS - 4'd1;
        end
      end else if (soft_reset_o) begin
        // Command writes are ignored until the sequence ends
        command_opcode       <= `ISC_OP_SOFT_RESET;
        mode                 <= M_IDLE;
        mode_o               <= M_IDLE;
        pause_o              <= 1'b0;
        bus_float_o          <= 1'b0;
        first_port_cfg_en_o  <= 1'b0;
        second_port_cfg_en_o <= 1'b0;
        if (sr_count == 4'd0) begin
          soft_reset_o <= 1'b0;
        end else begin
          sr_count <= sr_count - 4'd1;
        end
      end
    end
  end

endmodule // isc_core
`default_nettype wire

// *** isc_properties.sv ***
// Concurrent checks on the ports of the status and command block
// Assumes it is bound onto every isc_core instance
`timescale 1ns/1ps
`default_nettype none
// ********************
// Checker
// ********************
module isc_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       out_port_done_i,
  input wire logic       xfer_event_i,
  input wire logic       suppressed_last_eor_i,
  input wire logic [7:0] error_status_i,
  input wire logic [7:0] error_mask_i,
  input wire logic       decoder_record_end_i,
  input wire logic       decoder_code_error_i,
  input wire logic       start_pulse_o,
  input wire logic       pause_o,
  input wire logic       bus_float_o,
  input wire logic       soft_reset_o,
  input wire logic [7:0] interrupt_status_low_o,
  input wire logic [7:0] interrupt_status_high_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Counts soft reset cycles; a long repetition would be costly to unroll
  logic [3:0] sr_run = 4'h0;
  always @(posedge clk_i) begin
    if (rst_i || !soft_reset_o) sr_run <= 4'h0;
    else if (sr_run != 4'hf) sr_run <= sr_run + 4'h1;
  end
  chk_done_flag_set: assert property (out_port_done_i |=> interrupt_status_low_o[7])
    else $error("done flag missed");
  chk_pause_flag_set: assert property (xfer_event_i |=> interrupt_status_low_o[6])
    else $error("pause flag missed");
  chk_outoff_flag_set: assert property (suppressed_last_eor_i |=> interrupt_status_low_o[5])
    else $error("output off flag missed");
  chk_error_flag_set: assert property (|(error_status_i & ~error_mask_i) |=>
    interrupt_status_low_o[0]) else $error("error flag missed");
  chk_decoder_end_set: assert property (decoder_record_end_i || decoder_code_error_i
    |=> interrupt_status_high_o[7]) else $error("decoder flag missed");
  chk_hw_reset_zero: assert property ($fell(rst_i) |->
    interrupt_status_low_o == 8'h00 && interrupt_status_high_o == 8'h00) else $error("flags after reset");
  chk_start_one_cycle: assert property (start_pulse_o |=> !start_pulse_o)
    else $error("start pulse too long");
  chk_soft_reset_len: assert property ($fell(soft_reset_o) |-> sr_run == 4'd12)
    else $error("soft reset length");
  chk_soft_reset_max: assert property (soft_reset_o |-> sr_run < 4'd12)
    else $error("soft reset too long");
  chk_pause_floats: assert property (pause_o |-> bus_float_o)
    else $error("bus not floated in pause");
  chk_pause_raises: assert property ($rose(pause_o) |-> ##[0:1] interrupt_status_low_o[6])
    else $error("pause without flag");
  cover property ($rose(soft_reset_o));
  cover property (start_pulse_o);
  cover property ($rose(pause_o));
endmodule // isc_properties
bind isc_core isc_properties i_isc_properties (.*);
`default_nettype wire

// *** isc_host.sv ***
// Host processor model: classic Wishbone single-cycle master
// Assumes a slave that answers with a registered ack
`timescale 1ns/1ps
`default_nettype none
// ********************
// Bus master
// ********************
module isc_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] adr_o = 32'h0,
  output var  logic [31:0] dat_o = 32'h0,
  output var  logic [3:0]  sel_o = 4'h0,
  output var  logic        we_o = 1'b0,
  output var  logic        cyc_o = 1'b0,
  output var  logic        stb_o = 1'b0
);
  // Caller keeps opcodes legal and stays off the bus during soft reset
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] d, output logic [31:0] q);
    begin
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o <= w;
      sel_o <= 4'hf;
      adr_o <= {22'h0, idx, 2'b00};
      dat_o <= d;
      @(posedge clk_i);
      while (ack_i !== 1'b1) @(posedge clk_i);
      q = dat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      we_o <= 1'b0;
      // Released lines must not keep showing the last value
      dat_o <= ~d;
      adr_o <= ~adr_o;
    end
  endtask
endmodule // isc_host
`default_nettype wire

// *** isc_tb_top.sv ***
// Self-checking bench: integer flag model compared with register reads
// Assumes isc_core with the host model as bus master
`timescale 1ns/1ps
`default_nettype none
`include "isc_regs.vh"
// ********************
// Bench
// ********************
module irq_status_and_command_decode_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1;
  logic [31:0] adr_i, dat_i, dat_o, q;
  logic [3:0]  sel_i;
  logic        we_i, cyc_i, stb_i, ack_o;
  logic [4:0]  ev = 5'h0;
  logic [7:0]  error_status_i = 8'h0, error_mask_i = 8'h0;
  logic        a_last_i = 1'b0, a_one_i = 1'b0, b_byte_i = 1'b0;
  logic        b_last_i = 1'b0, b_one_i = 1'b0, a_byte_i = 1'b0;
  logic        xfer_last_word_i = 1'b0, record_length_zero_i = 1'b0;
  logic        first_port_cfg_en_o, second_port_cfg_en_o, start_pulse_o;
  logic        pause_o, bus_float_o, soft_reset_o;
  logic [2:0]  mode_o;
  logic [1:0]  pad_expect_o, pad_insert_o;
  logic [7:0]  interrupt_status_low_o, interrupt_status_high_o;
  wire         out_port_done_i = ev[0], xfer_event_i = ev[1], suppressed_last_eor_i = ev[2];
  wire         decoder_record_end_i = ev[3], decoder_code_error_i = ev[4];
  integer      error_cnt = 0, samples_checked = 0, cycles = 0, m_lo, m_hi, n, i;
  isc_core i_isc_core (.*);
  isc_host i_isc_host (.clk_i(clk_i), .ack_i(ack_o), .dat_i(dat_o), .adr_o(adr_i), .dat_o(dat_i),
    .sel_o(sel_i), .we_o(we_i), .cyc_o(cyc_i), .stb_o(stb_i));
  initial forever #2.5 clk_i = ~clk_i;
  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Hang guard, far beyond the roughly 145 cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdc(input logic [7:0] idx, input logic [31:0] exp);
    i_isc_host.xfer(1'b0, idx, 32'h0, q);
    cmp(q, exp);
  endtask
  task wr(input logic [7:0] idx, input logic [31:0] d);
    i_isc_host.xfer(1'b1, idx, d, q);
  endtask
  task pulse(input logic [4:0] v);
    @(posedge clk_i);
    ev <= v;
    @(posedge clk_i);
    ev <= 5'h0;
    m_lo = m_lo | (v[0] ? 8'h80 : 0) | (v[1] ? 8'h40 : 0) | (v[2] ? 8'h20 : 0);
    m_hi = m_hi | (v[3] | v[4] ? 8'h80 : 0);
  endtask
  task note(input string s);
    $display("test %0s done", s);
  endtask
  initial begin
    void'($urandom(20485));
    m_lo = 0;
    m_hi = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`ISC_IDX_INT_LOW, 0);
    rdc(`ISC_IDX_INT_HIGH, 0);
    rdc(`ISC_IDX_CMD, `ISC_RST_CMD_HW);
    note("reset");
    for (i = 0; i < 6; i++) pulse(5'($urandom));
    rdc(`ISC_IDX_INT_LOW, m_lo);
    rdc(`ISC_IDX_INT_HIGH, m_hi);
    @(posedge clk_i);
    error_mask_i <= 8'h02;
    error_status_i <= 8'h02;
    rdc(`ISC_IDX_INT_LOW, m_lo);
    error_mask_i <= 8'h00;
    @(posedge clk_i);
    error_status_i <= 8'h00;
    m_lo = m_lo | 1;
    wr(`ISC_IDX_INT_LOW, 0);
    m_lo = m_lo & 1;
    rdc(`ISC_IDX_INT_LOW, m_lo);
    wr(`ISC_IDX_INT_HIGH, 8'h7f);
    m_hi = m_hi & 8'h7f;
    rdc(`ISC_IDX_INT_HIGH, m_hi);
    note("flags");
    wr(`ISC_IDX_CMD, 16'h6806);
    cmp({25'h0, mode_o, pad_expect_o, pad_insert_o}, {25'h0, 3'd4, 2'd1, 2'd2});
    @(posedge clk_i);
    {a_last_i, a_one_i} <= 2'b11;
    @(posedge clk_i);
    {a_last_i, a_one_i} <= 2'b00;
    // Compare count is still zero, so the count match flag is up as well
    rdc(`ISC_IDX_INT_HIGH, m_hi | 8'h43);
    wr(`ISC_IDX_COMPARE, 3);
    wr(`ISC_IDX_CMD, 16'h5809);
    cmp({25'h0, mode_o, pad_expect_o, pad_insert_o}, {25'h0, 3'd2, 2'd2, 2'd1});
    m_lo = 0;
    m_hi = 0;
    rdc(`ISC_IDX_INT_LOW, m_lo);
    cmp(interrupt_status_low_o, m_lo);
    rdc(`ISC_IDX_INT_HIGH, m_hi);
    n = 1 + $urandom % 5;
    repeat (n) begin
      @(posedge clk_i);
      b_byte_i <= 1'b1;
      @(posedge clk_i);
      b_byte_i <= 1'b0;
    end
    m_hi = n >= 3 ? 8'h40 : 8'h00;
    rdc(`ISC_IDX_INT_HIGH, m_hi);
    cmp(interrupt_status_high_o, m_hi);
    rdc(`ISC_IDX_BYTE_COUNT, n);
    wr(`ISC_IDX_EVENT_MASK, 4'h2);
    @(posedge clk_i);
    {record_length_zero_i, b_last_i, b_one_i} <= 3'b111;
    @(posedge clk_i);
    {record_length_zero_i, b_last_i, b_one_i} <= 3'b000;
    m_hi = m_hi | 8'h30;
    rdc(`ISC_IDX_INT_HIGH, m_hi);
    @(posedge clk_i);
    {record_length_zero_i, xfer_last_word_i} <= 2'b11;
    @(posedge clk_i);
    {record_length_zero_i, xfer_last_word_i} <= 2'b00;
    m_hi = m_hi | 8'h01;
    rdc(`ISC_IDX_INT_HIGH, m_hi);
    note("modes");
    wr(`ISC_IDX_CMD, `ISC_OP_SEL_A);
    cmp({30'h0, first_port_cfg_en_o, second_port_cfg_en_o}, 2'b10);
    rdc(`ISC_IDX_CMD, `ISC_OP_SEL_A);
    cmp({30'h0, first_port_cfg_en_o, second_port_cfg_en_o}, 2'b10);
    wr(`ISC_IDX_CMD, `ISC_OP_SEL_B);
    cmp({30'h0, first_port_cfg_en_o, second_port_cfg_en_o}, 2'b01);
    wr(`ISC_IDX_CMD, `ISC_OP_PAUSE);
    repeat (2) @(posedge clk_i);
    cmp({30'h0, pause_o, bus_float_o}, 2'b11);
    rdc(`ISC_IDX_INT_LOW, 8'h40);
    wr(`ISC_IDX_CMD, `ISC_OP_SOFT_RESET);
    repeat (14) @(posedge clk_i);
    cmp({27'h0, soft_reset_o, pause_o, mode_o}, 0);
    rdc(`ISC_IDX_CMD, `ISC_OP_SOFT_RESET);
    rdc(`ISC_IDX_INT_LOW, 0);
    cmp(interrupt_status_high_o, 0);
    note("commands");
    finish_test();
  end
endmodule // irq_status_and_command_decode_tb_top
`default_nettype wire
